// File: hdl/csp_serial_port.sv
// Clocked serial I/O port with AHB-Lite registers and interrupt
//
// Functional notes
// - Clock select 00 external pin, 01 fx/16, 10 fx/128, 11 fx/1024.
// - Internal divided clock is driven out on the clock pin.
// - Enable 1 makes the three pins serial; 0 leaves them general port pins.
// - Start write with enable begins shifting at next falling serial clock edge.
// - Starting a transfer clears the transfer done flag.
// - MSB first only; MSB goes to data out at each falling edge.
// - Each rising edge shifts left and loads data in into the LSB.
// - After eight bits the start bit self-clears and done flag sets.
// - A 3-bit counter counts serial clocks; flag raised after eight.
// - Data out latch is the port output latch of the tx pin.
// - Data in is captured in both send/receive and receive-only modes.
// - Float bit tri-states data out; tx pin is then an input.
// - Start bit zero: no shifting, shift register is plain storage.
// - Writing zero to start bit aborts a transfer, no restart.
// - Reset clears start, float and clock-select bits.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "csp_defs.svh"
module csp_serial_port #(
    parameter logic [9:0] HALF_DIV16   = `CSP_HALF_DIV16,
    parameter logic [9:0] HALF_DIV128  = `CSP_HALF_DIV128,
    parameter logic [9:0] HALF_DIV1024 = `CSP_HALF_DIV1024
) (
    // Clock and reset
    input  wire logic                 I_MCLK,
    input  wire logic                 I_SYS_RST,
    // AHB-Lite slave
    input  wire logic                 I_HSEL,
    input  wire logic [31:0]          I_HADDR,
    input  wire logic [1:0]           I_HTRANS,
    input  wire logic                 I_HWRITE,
    input  wire logic [31:0]          I_HWDATA,
    input  wire logic                 I_HREADY,
    output logic      [31:0]          O_HRDATA,
    output logic                      O_HREADYOUT,
    output logic                      O_HRESP,
    // Port pins: clock, data out, data in
    input  wire csp_pkg::csp_pins_t   I_PIN_IN,
    output csp_pkg::csp_pins_t        O_PIN_OUT,
    output csp_pkg::csp_pins_t        O_PIN_OE,
    // Interrupt
    output logic                      O_IRQ
);

    csp_pkg::csp_state_t state;
    csp_pkg::csp_state_t next_state;
    csp_pkg::csp_pins_t  pin_sync;
    logic [9:0]          half;
    logic                int_sel;
    logic                active;
    logic                div_tick;
    logic                fall_ev;
    logic                rise_ev;
    logic                wr_ctrl;
    logic                go_wr;
    logic                stop_wr;
    logic                done;
    logic                flag_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    csp_sync #(
        .W       (3),
        .RST_VAL (`CSP_SYNC_RST)
    ) u_sync (
        .i_clk (I_MCLK),
        .i_rst (I_SYS_RST),
        .i_d   (I_PIN_IN),
        .o_q   (pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux

    function automatic logic [31:0] read_word(input csp_pkg::csp_state_t s,
                                              input csp_pkg::csp_pins_t  p);
        logic [31:0] w;
        w = '0;
        case (s.ahb_addr)
            `CSP_ADDR_SHIFT:  w = 32'(s.shift_reg);
            `CSP_ADDR_PORT:   w = 32'(s.port_out);
            `CSP_ADDR_CTRL:   w = 32'(s.ctrl);
            `CSP_ADDR_DIR:    w = 32'(s.port_dir);
            `CSP_ADDR_STATUS: w = 32'(s.transfer_done_irq);
            `CSP_ADDR_MASK:   w = 32'(s.irq_mask);
            `CSP_ADDR_PINS:   w = 32'({s.xfer != csp_pkg::CSP_ST_IDLE, s.bit_cnt, p});
            default:          w = '0;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;

        // Clock source and divider length
        int_sel = state.ctrl.clk_select_hi | state.ctrl.clk_select_lo;
        case ({state.ctrl.clk_select_hi, state.ctrl.clk_select_lo})
            2'b01:   half = HALF_DIV16;
            2'b10:   half = HALF_DIV128;
            default: half = HALF_DIV1024;
        endcase
        active   = state.xfer != csp_pkg::CSP_ST_IDLE;
        div_tick = state.div_cnt == (half - 10'h001);

        // Serial clock edges from the divider or from the pin
        if (int_sel) begin
            fall_ev = active & div_tick & state.sck_int;
            rise_ev = active & div_tick & ~state.sck_int;
        end else begin
            fall_ev = state.sck_prev & ~pin_sync.port_pin_clock;
            rise_ev = ~state.sck_prev & pin_sync.port_pin_clock;
        end
        next_state.sck_prev = pin_sync.port_pin_clock;

        // Divider runs only during a transfer, clock parks high
        if (active && int_sel) begin
            if (div_tick) begin
                next_state.div_cnt = '0;
                next_state.sck_int = ~state.sck_int;
            end else begin
                next_state.div_cnt = state.div_cnt + 10'h001;
            end
        end else begin
            next_state.div_cnt = '0;
            next_state.sck_int = 1'b1;
        end

        // Register writes in the data phase
        wr_ctrl  = state.ahb_wr && (state.ahb_addr == `CSP_ADDR_CTRL);
        go_wr    = wr_ctrl && I_HWDATA[`CSP_CTRL_GO] && I_HWDATA[`CSP_CTRL_EN] && !active;
        stop_wr  = wr_ctrl && !I_HWDATA[`CSP_CTRL_GO];
        flag_clr = state.ahb_wr && (state.ahb_addr == `CSP_ADDR_STATUS)
                   && I_HWDATA[`CSP_IRQ_BIT];
        if (wr_ctrl) begin
            next_state.ctrl = csp_pkg::csp_ctrl_t'(I_HWDATA[`CSP_CTRL_MSB:0]);
            next_state.ctrl.transfer_go = state.ctrl.transfer_go;
        end
        if (state.ahb_wr && (state.ahb_addr == `CSP_ADDR_PORT)) begin
            next_state.port_out = csp_pkg::csp_pins_t'(I_HWDATA[`CSP_PINS_MSB:0]);
        end
        if (state.ahb_wr && (state.ahb_addr == `CSP_ADDR_DIR)) begin
            next_state.port_dir = csp_pkg::csp_pins_t'(I_HWDATA[`CSP_PINS_MSB:0]);
        end
        if (state.ahb_wr && (state.ahb_addr == `CSP_ADDR_MASK)) begin
            next_state.irq_mask = I_HWDATA[`CSP_IRQ_BIT];
        end
        // Storage write only while stopped, so shifting cannot be corrupted
        if (state.ahb_wr && (state.ahb_addr == `CSP_ADDR_SHIFT) && !active) begin
            next_state.shift_reg = I_HWDATA[`CSP_SHIFT_MSB:0];
        end

        // Transfer sequencer
        done = 1'b0;
        case (state.xfer)
            csp_pkg::CSP_ST_IDLE: begin
                if (go_wr) begin
                    next_state.ctrl.transfer_go = 1'b1;
                    next_state.bit_cnt          = '0;
                    next_state.xfer             = csp_pkg::CSP_ST_WAIT_FALL;
                end
            end
            csp_pkg::CSP_ST_WAIT_FALL, csp_pkg::CSP_ST_HIGH: begin
                if (fall_ev) begin
                    next_state.port_out.port_pin_tx = state.shift_reg[`CSP_SHIFT_MSB];
                    next_state.xfer = csp_pkg::CSP_ST_LOW;
                end
            end
            csp_pkg::CSP_ST_LOW: begin
                if (rise_ev) begin
                    // Data in sampled whatever the float bit says
                    next_state.shift_reg = {state.shift_reg[`CSP_SHIFT_MSB-1:0],
                                            pin_sync.port_pin_rx};
                    next_state.bit_cnt   = state.bit_cnt + 3'h1;
                    if (state.bit_cnt == `CSP_LAST_BIT) begin
                        done = 1'b1;
                        next_state.ctrl.transfer_go = 1'b0;
                        next_state.xfer = csp_pkg::CSP_ST_IDLE;
                    end else begin
                        next_state.xfer = csp_pkg::CSP_ST_HIGH;
                    end
                end
            end
            default: begin
                next_state.xfer = csp_pkg::CSP_ST_IDLE;
            end
        endcase

        // Forced stop by software or by leaving serial mode
        if (active && (stop_wr || !next_state.ctrl.serial_pin_enable)) begin
            next_state.ctrl.transfer_go = 1'b0;
            next_state.xfer             = csp_pkg::CSP_ST_IDLE;
            next_state.bit_cnt          = '0;
            next_state.div_cnt          = '0;
            next_state.sck_int          = 1'b1;
        end

        // Done flag: a completion beats a clear in the same cycle
        next_state.transfer_done_irq = (state.transfer_done_irq & ~flag_clr & ~go_wr)
                                       | done;
        next_state.irq = next_state.transfer_done_irq & next_state.irq_mask;

        // Pin drivers
        if (next_state.ctrl.serial_pin_enable) begin
            // Select bits just written decide the pin, so no stale input phase
            next_state.pin_oe.port_pin_clock  = next_state.ctrl.clk_select_hi
                                                | next_state.ctrl.clk_select_lo;
            next_state.pin_out.port_pin_clock = next_state.pin_oe.port_pin_clock
                                                ? next_state.sck_int
                                                : next_state.port_out.port_pin_clock;
            next_state.pin_oe.port_pin_tx     = ~next_state.ctrl.dout_float;
            next_state.pin_oe.port_pin_rx     = 1'b0;
        end else begin
            next_state.pin_oe  = next_state.port_dir;
            next_state.pin_out = next_state.port_out;
        end
        next_state.pin_out.port_pin_tx = next_state.port_out.port_pin_tx;
        next_state.pin_out.port_pin_rx = next_state.port_out.port_pin_rx;

        // AHB-Lite: writes zero-wait, reads one wait state
        next_state.hresp  = 1'b0;
        next_state.ahb_wr = 1'b0;
        if (state.ahb_rd_pend) begin
            next_state.hrdata      = read_word(state, pin_sync);
            next_state.hreadyout   = 1'b1;
            next_state.ahb_rd_pend = 1'b0;
        end else if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
            next_state.ahb_addr = I_HADDR[7:0];
            next_state.ahb_wr   = I_HWRITE;
            if (!I_HWRITE) begin
                next_state.ahb_rd_pend = 1'b1;
                next_state.hreadyout   = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state           <= '0;
            state.xfer      <= csp_pkg::CSP_ST_IDLE;
            state.sck_int   <= 1'b1;
            state.sck_prev  <= 1'b1;
            state.hrdata    <= `CSP_HRDATA_RST;
            state.hreadyout <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign O_HRDATA    = state.hrdata;
    assign O_HREADYOUT = state.hreadyout;
    assign O_HRESP     = state.hresp;
    assign O_PIN_OUT   = state.pin_out;
    assign O_PIN_OE    = state.pin_oe;
    assign O_IRQ       = state.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SYS_RST);

    sequence s_div16_low;
        ($fell(state.sck_int) && !state.ctrl.clk_select_hi && state.ctrl.clk_select_lo)
        ##1 (active && !state.sck_int)[*7];
    endsequence

    property p_div16_half;
        s_div16_low |=> state.sck_int;
    endproperty
    a_div16_half: assert property (p_div16_half) else $error("fx/16 half period wrong");

    property p_clk_drive;
        (state.ctrl.serial_pin_enable && int_sel)
            |-> (O_PIN_OE.port_pin_clock && O_PIN_OUT.port_pin_clock == state.sck_int);
    endproperty
    a_clk_drive: assert property (p_clk_drive) else $error("internal clock not driven");

    property p_gpio_mode;
        !state.ctrl.serial_pin_enable |-> (O_PIN_OE == state.port_dir);
    endproperty
    a_gpio_mode: assert property (p_gpio_mode) else $error("port mode pins wrong");

    property p_start;
        go_wr |=> (state.xfer == csp_pkg::CSP_ST_WAIT_FALL) && state.ctrl.transfer_go
                  && !state.transfer_done_irq;
    endproperty
    a_start: assert property (p_start) else $error("start write not taken");

    property p_msb_out;
        (fall_ev && (state.xfer == csp_pkg::CSP_ST_WAIT_FALL) && !stop_wr)
            |=> O_PIN_OUT.port_pin_tx == $past(state.shift_reg[`CSP_SHIFT_MSB]);
    endproperty
    a_msb_out: assert property (p_msb_out) else $error("MSB not on data out");

    property p_shift_in;
        (rise_ev && (state.xfer == csp_pkg::CSP_ST_LOW) && !stop_wr
         && next_state.ctrl.serial_pin_enable)
            |=> state.shift_reg == {$past(state.shift_reg[6:0]), $past(pin_sync.port_pin_rx)};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift in wrong");

    sequence s_last_rise;
        (state.xfer == csp_pkg::CSP_ST_LOW) && rise_ev && (state.bit_cnt == `CSP_LAST_BIT)
        && !stop_wr && next_state.ctrl.serial_pin_enable;
    endsequence

    property p_done;
        s_last_rise |=> (state.transfer_done_irq && !state.ctrl.transfer_go
                         && state.xfer == csp_pkg::CSP_ST_IDLE);
    endproperty
    a_done: assert property (p_done) else $error("end of byte not flagged");

    property p_float;
        (state.ctrl.serial_pin_enable && state.ctrl.dout_float) |-> !O_PIN_OE.port_pin_tx;
    endproperty
    a_float: assert property (p_float) else $error("data out driven while floated");

    property p_stopped_store;
        (!active && !go_wr && !(state.ahb_wr && state.ahb_addr == `CSP_ADDR_SHIFT))
            |=> $stable(state.shift_reg);
    endproperty
    a_stopped_store: assert property (p_stopped_store) else $error("shift while stopped");

    property p_abort;
        (active && stop_wr)
            |=> (state.xfer == csp_pkg::CSP_ST_IDLE && !state.ctrl.transfer_go)
                ##1 (state.xfer == csp_pkg::CSP_ST_IDLE || $past(go_wr));
    endproperty
    a_abort: assert property (p_abort) else $error("stop write did not abort");

    property p_idle_high;
        (!active && int_sel) |-> state.sck_int;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("clock not idle high");

    property p_irq_out;
        ##1 (O_IRQ == $past(next_state.transfer_done_irq && next_state.irq_mask));
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt output wrong");

endmodule

// File: hdl/csp_defs.svh
// Register map, field positions and divider constants of the clocked serial port
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// Byte addresses (low address byte only is decoded)
`define CSP_ADDR_SHIFT   8'h00
`define CSP_ADDR_PORT    8'h04
`define CSP_CTRL_INDEX   8'h02
`define CSP_ADDR_CTRL    (`CSP_CTRL_INDEX << 2)
`define CSP_ADDR_DIR     8'h0c
`define CSP_ADDR_STATUS  8'h10
`define CSP_ADDR_MASK    8'h14
`define CSP_ADDR_PINS    8'h18

// Control word fields
`define CSP_CTRL_MSB     4
`define CSP_CTRL_EN      4
`define CSP_CTRL_GO      3

// Pin group, status and shift register fields
`define CSP_PINS_MSB     2
`define CSP_IRQ_BIT      0
`define CSP_SHIFT_MSB    7

// Half periods of the internal serial clock, in system clocks
`define CSP_HALF_DIV16   10'h008
`define CSP_HALF_DIV128  10'h040
`define CSP_HALF_DIV1024 10'h200

// Bit counter value on the last bit of a byte
`define CSP_LAST_BIT     3'h7

// Reset values
`define CSP_SYNC_RST     3'h7
`define CSP_HRDATA_RST   32'h0000_0000

`endif

// File: hdl/csp_pkg.sv
// Types shared by the clocked serial port files
package csp_pkg;

    typedef enum logic [1:0] {
        CSP_ST_IDLE      = 2'b00,
        CSP_ST_WAIT_FALL = 2'b01,
        CSP_ST_LOW       = 2'b10,
        CSP_ST_HIGH      = 2'b11
    } csp_xfer_t;

    typedef struct packed {
        logic serial_pin_enable;
        logic transfer_go;
        logic dout_float;
        logic clk_select_hi;
        logic clk_select_lo;
    } csp_ctrl_t;

    typedef struct packed {
        logic port_pin_rx;
        logic port_pin_tx;
        logic port_pin_clock;
    } csp_pins_t;

    typedef struct packed {
        csp_ctrl_t   ctrl;
        logic [7:0]  shift_reg;
        csp_pins_t   port_out;
        csp_pins_t   port_dir;
        logic        transfer_done_irq;
        logic        irq_mask;
        logic        irq;
        csp_xfer_t   xfer;
        logic [2:0]  bit_cnt;
        logic [9:0]  div_cnt;
        logic        sck_int;
        logic        sck_prev;
        csp_pins_t   pin_out;
        csp_pins_t   pin_oe;
        logic        ahb_wr;
        logic        ahb_rd_pend;
        logic [7:0]  ahb_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } csp_state_t;

endpackage

// File: hdl/csp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module csp_sync #(
    parameter int         W       = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Pin levels in, filtered levels out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // A change counts only once stages two and three agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1  <= RST_VAL;
            s2  <= RST_VAL;
            s3  <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            s1 <= i_d;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    o_q[i] <= s3[i];
                end
            end
        end
    end

endmodule

// File: bench/csp_peer.sv
// Behavioural serial peripheral on the clock, data out and data in lines
`timescale 1ns/1ps
module csp_peer #(
    parameter int HALF = 16
) (
    // Clock and controls
    input  wire logic       i_clk,
    input  wire logic       i_clr,
    input  wire logic       i_ext_go,
    input  wire logic [7:0] i_send,
    // Serial lines
    input  wire logic       i_sck,
    input  wire logic       i_tx,
    output logic            o_sck = 1'b1,
    output logic            o_rx = 1'b0,
    output logic [7:0]      o_got = 8'h00
);
    logic       sck_d = 1'b1;
    logic       in_frame = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [4:0] left = 5'h00;
    int         tmr = 0;

    always @(posedge i_clk) begin
        sck_d <= i_sck;
        // Exactly eight pulses, clock stands high between frames
        if (i_ext_go) begin
            left <= 5'h10;
            tmr  <= HALF;
        end else if (left != 5'h00) begin
            if (tmr == 1) begin
                o_sck <= ~o_sck;
                left  <= left - 5'h01;
                tmr   <= HALF;
            end else begin
                tmr <= tmr - 1;
            end
        end
        if (i_clr) begin
            idx      <= 3'h0;
            in_frame <= 1'b0;
        end else if (sck_d && !i_sck) begin
            // New bit just after the fall, held through the next rise
            o_rx     <= i_send[3'h7 - idx];
            in_frame <= 1'b1;
        end else if (!sck_d && i_sck) begin
            o_got    <= {o_got[6:0], i_tx};
            idx      <= idx + 3'h1;
            in_frame <= (idx != 3'h7);
        end else if (!in_frame) begin
            // Released line keeps moving so no stale bit looks valid
            o_rx <= ~o_rx;
        end
    end
endmodule

// File: bench/csp_serial_port_tb.sv
// Self-checking bench of the clocked serial port with a serial peer
`timescale 1ns/1ps
`include "csp_defs.svh"
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module csp_serial_port_tb;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'b00;
    logic               hwrite = 1'b0;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        hrdata;
    logic               hready;
    logic               hresp;
    csp_pkg::csp_pins_t pin_in;
    csp_pkg::csp_pins_t pin_out;
    csp_pkg::csp_pins_t pin_oe;
    logic               irq;
    logic               peer_sck;
    logic               peer_rx;
    logic [7:0]         peer_got;
    logic [7:0]         send = 8'h00;
    logic               ext_go = 1'b0;
    logic               clr = 1'b0;
    logic               tog = 1'b0;
    logic               rd_dp = 1'b0;
    logic               ck_d = 1'b1;
    int                 cyc = 0;
    int                 t_fall = 0;
    int                 per = 0;
    int                 fail_count = 0;
    int                 tests_run = 0;
    integer             seed = 32'h9aeb77f9;
    logic [31:0]        exp_q[$];
    logic [31:0]        exp_w;

    always #10 clk = ~clk;

    // Wire levels from every driver
    assign pin_in.port_pin_clock = pin_oe.port_pin_clock ? pin_out.port_pin_clock : peer_sck;
    assign pin_in.port_pin_tx    = pin_oe.port_pin_tx ? pin_out.port_pin_tx : tog;
    assign pin_in.port_pin_rx    = pin_oe.port_pin_rx ? pin_out.port_pin_rx : peer_rx;

    csp_serial_port csp_serial_port_inst (
        .I_MCLK      (clk),
        .I_SYS_RST   (rst),
        .I_HSEL      (1'b1),
        .I_HADDR     (haddr),
        .I_HTRANS    (htrans),
        .I_HWRITE    (hwrite),
        .I_HWDATA    (hwdata),
        .I_HREADY    (hready),
        .O_HRDATA    (hrdata),
        .O_HREADYOUT (hready),
        .O_HRESP     (hresp),
        .I_PIN_IN    (pin_in),
        .O_PIN_OUT   (pin_out),
        .O_PIN_OE    (pin_oe),
        .O_IRQ       (irq)
    );

    csp_peer #(.HALF(16)) csp_peer_inst (
        .i_clk    (clk),
        .i_clr    (clr),
        .i_ext_go (ext_go),
        .i_send   (send),
        .i_sck    (pin_in.port_pin_clock),
        .i_tx     (pin_in.port_pin_tx),
        .o_sck    (peer_sck),
        .o_rx     (peer_rx),
        .o_got    (peer_got)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask

    function automatic int period_of(input logic [1:0] s);
        case (s)
            2'b01:   return 2 * `CSP_HALF_DIV16;
            2'b10:   return 2 * `CSP_HALF_DIV128;
            default: return 2 * `CSP_HALF_DIV1024;
        endcase
    endfunction

    // Read results, clock period and the hang limit
    always @(posedge clk) begin
        if (rd_dp && hready === 1'b1) begin
            exp_w = exp_q.pop_front();
            `CHK("hrdata", exp_w, hrdata)
            `CHK("hresp", 1'b0, hresp)
        end
        if (hready) rd_dp <= htrans[1] & ~hwrite;
        cyc  <= cyc + 1;
        ck_d <= pin_in.port_pin_clock;
        tog  <= ~tog;
        if (ck_d && !pin_in.port_pin_clock) begin
            per    <= cyc - t_fall;
            t_fall <= cyc;
        end
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic [1:0] sel, input logic flt);
        logic [7:0] tx;
        logic [7:0] rx;
        int         n;
        tx = 8'($random(seed));
        rx = 8'($random(seed));
        send <= rx;
        clr  <= 1'b1;
        wr(`CSP_ADDR_SHIFT, {24'h0, tx});
        clr <= 1'b0;
        wr(`CSP_ADDR_CTRL, {27'h0, 2'b11, flt, sel});
        rd(`CSP_ADDR_STATUS, 32'h0);
        if (sel == 2'b00) begin
            ext_go <= 1'b1;
            @(posedge clk);
            ext_go <= 1'b0;
        end
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        `CHK("irq", 1'b1, irq)
        // Peer takes the last bit one edge after the final clock rise
        repeat (2) @(posedge clk);
        if (!flt) `CHK("peer_got", tx, peer_got)
        `CHK("tx_oe", ~flt, pin_oe.port_pin_tx)
        if (sel != 2'b00) `CHK("period", period_of(sel), per)
        `CHK("ck_oe", sel != 2'b00, pin_oe.port_pin_clock)
        rd(`CSP_ADDR_SHIFT, {24'h0, rx});
        rd(`CSP_ADDR_CTRL, {27'h0, 2'b10, flt, sel});
        rd(`CSP_ADDR_STATUS, 32'h1);
        wr(`CSP_ADDR_MASK, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("irq_masked", 1'b0, irq)
        wr(`CSP_ADDR_MASK, 32'h1);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(`CSP_ADDR_CTRL, 32'h0);
        rd(`CSP_ADDR_MASK, 32'h0);
        `CHK("oe_rst", 3'b000, pin_oe)
        wr(`CSP_ADDR_SHIFT, 32'h0000_00a5);
        rd(`CSP_ADDR_SHIFT, 32'h0000_00a5);
        rd(8'h1c, 32'h0);
        wr(`CSP_ADDR_MASK, 32'h1);
        for (int s = 1; s < 4; s++) xfer(2'(s), 1'b0);
        xfer(2'b00, 1'b0);
        xfer(2'b00, 1'b1);
        xfer(2'b01, 1'b1);
        // Stop in mid-byte
        wr(`CSP_ADDR_CTRL, 32'h0000_0019);
        repeat (40) @(posedge clk);
        wr(`CSP_ADDR_CTRL, 32'h0000_0011);
        repeat (300) @(posedge clk);
        rd(`CSP_ADDR_STATUS, 32'h0);
        rd(`CSP_ADDR_CTRL, 32'h0000_0011);
        `CHK("ck_idle", 1'b1, pin_out.port_pin_clock)
        wr(`CSP_ADDR_PORT, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("tx_latch", 1'b0, pin_out.port_pin_tx)
        wr(`CSP_ADDR_PORT, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("tx_latch", 1'b1, pin_out.port_pin_tx)
        wr(`CSP_ADDR_CTRL, 32'h0);
        wr(`CSP_ADDR_DIR, 32'h7);
        wr(`CSP_ADDR_PORT, 32'h5);
        repeat (3) @(posedge clk);
        `CHK("port_oe", 3'b111, pin_oe)
        `CHK("port_out", 3'b101, pin_out)
        rd(`CSP_ADDR_PINS, 32'h5);
        final_report();
    end
endmodule
